// ### rtl/pfc_top.sv
// What this block does
// R01: Global enable low forces every clock output off; high lets per-output enables act.
// R02: Tap port enable drives the oscillator tap port when set; off after reset.
// R03: Reference-path delay code inserts code times 150 ps, default zero, outputs lag.
// R04: Each feedback word write starts calibration unless zero-delay mode is selected.
// R05: Each feedback word write starts a global output divider synchronization.
// R06: Feedback divider is plain binary 1 to 262143, default 760; zero is refused.
// R07: Total feedback ratio equals feedback divider times post-divider value.
// R08: Post-divider codes 2 to 8 divide by the code, default 2; others refused.
// R09: Post-divider stays in the path; no setting bypasses it.
// R10: Pump gain codes 0 to 3 give 1x, 4x, 16x, 32x; reset 1x.
// R11: Feedback-path delay code inserts code times 150 ps, default zero, outputs lead.
// R12: Clock outputs run only while the gate pin is high.
// R13: Host rewrites the feedback word after a reference divider change.
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "pfc_cfg.svh"
module pfc_top #(
  parameter int NUM_OUT  = 8,
  parameter int CAL_CYC  = `PFC_CAL_CYC,
  parameter int SYNC_CYC = `PFC_SYNC_CYC
) (
  // Clock and reset.
  input  wire logic           aclk,
  input  wire logic           aresetn,
  // AXI4-Lite write address channel.
  input  wire logic [7:0]     s_axi_awaddr,
  input  wire logic [2:0]     s_axi_awprot,
  input  wire logic           s_axi_awvalid,
  output logic                s_axi_awready,
  // AXI4-Lite write data channel.
  input  wire logic [31:0]    s_axi_wdata,
  input  wire logic [3:0]     s_axi_wstrb,
  input  wire logic           s_axi_wvalid,
  output logic                s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0]          s_axi_bresp,
  output logic                s_axi_bvalid,
  input  wire logic           s_axi_bready,
  // AXI4-Lite read address channel.
  input  wire logic [7:0]     s_axi_araddr,
  input  wire logic [2:0]     s_axi_arprot,
  input  wire logic           s_axi_arvalid,
  output logic                s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp,
  output logic                s_axi_rvalid,
  input  wire logic           s_axi_rready,
  // Device pins.
  input  wire logic           global_output_gate_pin,
  input  wire logic           lock_indicator_pin,
  // Clock output and tap controls.
  output logic [NUM_OUT-1:0]  clk_out_enable,
  output logic                vco_tap_enable,
  // Phase detector skew controls.
  output pfc_pkg::pfc_code_t  reference_path_delay,
  output pfc_pkg::pfc_ps_t    reference_delay_ps,
  output pfc_pkg::pfc_code_t  feedback_path_delay,
  output pfc_pkg::pfc_ps_t    feedback_delay_ps,
  // Loop settings.
  output pfc_pkg::pfc_ndiv_t  feedback_divider,
  output pfc_pkg::pfc_code_t  oscillator_post_divider,
  output logic [1:0]          pump_gain_select,
  output logic [5:0]          pump_gain_mult,
  output pfc_pkg::pfc_ratio_t total_feedback_ratio,
  // Sequence strobes.
  output logic                cal_start,
  output logic                cal_busy,
  output logic                sync_start,
  output logic                sync_busy
);
  import pfc_pkg::*;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  pfc_fb_if fb ();

  // Software-visible state and write channel handshake state.
  logic [31:0]  ctrl;
  logic [31:0]  out_en;
  pfc_ndiv_t    n_div;
  pfc_code_t    post_code;
  logic [1:0]   gain_code;
  pfc_code_t    ndly_code;
  pfc_wstate_t  wstate;
  logic         aw_held;
  logic         w_held;
  logic [7:0]   aw_addr_q;
  logic [31:0]  w_data_q;
  logic [3:0]   w_strb_q;

  // Byte-lane merge of a write into an old value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Write channel capture: each channel is taken once and held until the response.
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs  = s_axi_wvalid & s_axi_wready;
  assign s_axi_awready = ~aw_held & (wstate == PFC_W_IDLE);
  assign s_axi_wready  = ~w_held & (wstate == PFC_W_IDLE);

  wire         have_aw  = aw_held | aw_hs;
  wire         have_w   = w_held | w_hs;
  wire         do_write = have_aw & have_w & (wstate == PFC_W_IDLE);
  wire  [7:0]  wr_addr  = aw_held ? aw_addr_q : s_axi_awaddr;
  wire  [31:0] wr_data  = w_held ? w_data_q : s_axi_wdata;
  wire  [3:0]  wr_strb  = w_held ? w_strb_q : s_axi_wstrb;

  // Write address decode.
  wire sel_ctrl  = (wr_addr == `PFC_OFS_CTRL);
  wire sel_outen = (wr_addr == `PFC_OFS_OUT_EN);
  wire sel_fb    = (wr_addr == `PFC_OFS_FB_WORD);
  wire sel_ro    = (wr_addr == `PFC_OFS_STATUS) | (wr_addr == `PFC_OFS_TOTAL);

  // Current feedback word and its merged candidate.
  wire [31:0] fb_word = {4'h0, ndly_code, gain_code, post_code, n_div};
  wire [31:0] fb_next = merge(fb_word, wr_data, wr_strb);
  wire [17:0] next_n  = fb_next[`PFC_FB_N_HI:`PFC_FB_N_LO];
  wire [3:0]  next_post = fb_next[`PFC_FB_POST_HI:`PFC_FB_POST_LO];

  // R06: zero divider refused.
  wire n_ok = (next_n != 18'h00000);
  // R08: post-divider codes outside 2 to 8 refused.
  // R09: a refused code never reaches the divider, so no bypass setting exists.
  wire post_ok = (next_post >= `PFC_POST_MIN) & (next_post <= `PFC_POST_MAX);
  wire fb_ok   = n_ok & post_ok;
  wire fb_take = do_write & sel_fb & fb_ok;
  wire wr_err  = ~(sel_ctrl | sel_outen | (sel_fb & fb_ok)) | sel_ro;

  // Holding registers for a channel that arrives before its partner.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      aw_held <= ~do_write & have_aw;
      w_held  <= ~do_write & have_w;
      if (aw_hs) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  // Write response state machine.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate       <= PFC_W_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      case (wstate)
        PFC_W_IDLE: begin
          if (do_write) begin
            wstate       <= PFC_W_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
          end
        end
        PFC_W_RESP: begin
          if (s_axi_bready) begin
            wstate       <= PFC_W_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wstate       <= PFC_W_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Control and per-output enable registers; only defined bits are kept.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl   <= `PFC_RST_CTRL;
      out_en <= `PFC_RST_OUT_EN;
    end else if (do_write) begin
      if (sel_ctrl) begin
        ctrl <= merge(ctrl, wr_data, wr_strb) & 32'h0000_00F7;
      end
      if (sel_outen) begin
        out_en <= merge(out_en, wr_data, wr_strb) & 32'((64'h1 << NUM_OUT) - 64'h1);
      end
    end
  end

  // R10: pump gain field kept with the feedback word.
  // R06: divider loaded only from an accepted write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      n_div     <= `PFC_RST_N;
      post_code <= `PFC_RST_POST;
      gain_code <= `PFC_RST_GAIN;
      ndly_code <= `PFC_RST_NDLY;
    end else if (fb_take) begin
      n_div     <= next_n;
      post_code <= next_post;
      gain_code <= fb_next[`PFC_FB_GAIN_HI:`PFC_FB_GAIN_LO];
      ndly_code <= fb_next[`PFC_FB_NDLY_HI:`PFC_FB_NDLY_LO];
    end
  end

  // Sequencer link.
  assign fb.wr_pulse   = fb_take;
  assign fb.zero_delay = ctrl[`PFC_CTRL_ZDM];
  assign fb.n_div      = n_div;
  assign fb.post_code  = post_code;

  pfc_fb_seq #(
    .CAL_CYC  (CAL_CYC),
    .SYNC_CYC (SYNC_CYC)
  ) u_seq (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fb      (fb)
  );

  assign cal_start            = fb.cal_start;
  assign cal_busy             = fb.cal_busy;
  assign sync_start           = fb.sync_start;
  assign sync_busy            = fb.sync_busy;
  assign total_feedback_ratio = fb.total_ratio;

  // Read path: one answer at a time, held until taken.
  wire        rd_hs = s_axi_arvalid & s_axi_arready;
  wire [31:0] status_word = {27'h0, 1'b0, fb.sync_busy, fb.cal_busy,
                             lock_indicator_pin, global_output_gate_pin};
  wire        rsel_ctrl  = (s_axi_araddr == `PFC_OFS_CTRL);
  wire        rsel_outen = (s_axi_araddr == `PFC_OFS_OUT_EN);
  wire        rsel_fb    = (s_axi_araddr == `PFC_OFS_FB_WORD);
  wire        rsel_stat  = (s_axi_araddr == `PFC_OFS_STATUS);
  wire        rsel_total = (s_axi_araddr == `PFC_OFS_TOTAL);
  wire        rd_hit     = rsel_ctrl | rsel_outen | rsel_fb | rsel_stat | rsel_total;
  wire [31:0] rd_mux = rsel_ctrl  ? ctrl :
                       rsel_outen ? out_en :
                       rsel_fb    ? fb_word :
                       rsel_stat  ? status_word :
                       rsel_total ? {10'h000, fb.total_ratio} : 32'h0000_0000;
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_hs) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Output gating: the global enable and the gate pin both override per-output enables.
  wire global_en = ctrl[`PFC_CTRL_GLOBAL];
  // R01: global enable overrides per-output enables.
  // R12: gate pin low stops all outputs.
  wire [NUM_OUT-1:0] next_clk_out_enable = (global_en & global_output_gate_pin) ?
                                           out_en[NUM_OUT-1:0] : '0;

  // Registered device-side controls.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_out_enable          <= '0;
      vco_tap_enable          <= 1'b0;
      reference_path_delay    <= 4'h0;
      reference_delay_ps      <= 12'h000;
      feedback_path_delay     <= 4'h0;
      feedback_delay_ps       <= 12'h000;
      feedback_divider        <= `PFC_RST_N;
      oscillator_post_divider <= `PFC_RST_POST;
      pump_gain_select        <= `PFC_RST_GAIN;
      pump_gain_mult          <= 6'h01;
    end else begin
      clk_out_enable          <= next_clk_out_enable;
      // R02: tap port follows its enable bit.
      vco_tap_enable          <= ctrl[`PFC_CTRL_TAP];
      // R03: lag delay in 150 ps steps.
      reference_path_delay    <= ctrl[`PFC_CTRL_RDLY_HI:`PFC_CTRL_RDLY_LO];
      reference_delay_ps      <= pfc_delay_ps(ctrl[`PFC_CTRL_RDLY_HI:`PFC_CTRL_RDLY_LO]);
      // R11: lead delay in 150 ps steps.
      feedback_path_delay     <= ndly_code;
      feedback_delay_ps       <= pfc_delay_ps(ndly_code);
      feedback_divider        <= n_div;
      oscillator_post_divider <= post_code;
      // R10: gain code to relative multiplier.
      pump_gain_select        <= gain_code;
      pump_gain_mult          <= pfc_gain_mult(gain_code);
    end
  end
endmodule

// ### inc/pfc_cfg.svh
// Offsets, fields, reset values and timing counts of the feedback block.
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH

// Register byte offsets.
`define PFC_OFS_CTRL    8'h00
`define PFC_OFS_OUT_EN  8'h04
`define PFC_OFS_FB_WORD 8'h08
`define PFC_OFS_STATUS  8'h0C
`define PFC_OFS_TOTAL   8'h10

// Control register fields.
`define PFC_CTRL_GLOBAL 0
`define PFC_CTRL_TAP    1
`define PFC_CTRL_ZDM    2
`define PFC_CTRL_RDLY_LO 4
`define PFC_CTRL_RDLY_HI 7

// Feedback configuration word fields.
`define PFC_FB_N_LO     0
`define PFC_FB_N_HI     17
`define PFC_FB_POST_LO  18
`define PFC_FB_POST_HI  21
`define PFC_FB_GAIN_LO  22
`define PFC_FB_GAIN_HI  23
`define PFC_FB_NDLY_LO  24
`define PFC_FB_NDLY_HI  27

// Reset values.
`define PFC_RST_CTRL    32'h0000_0001
`define PFC_RST_OUT_EN  32'h0000_0000
`define PFC_RST_N       18'h002F8
`define PFC_RST_POST    4'h2
`define PFC_RST_GAIN    2'h0
`define PFC_RST_NDLY    4'h0

// Post-divider code range.
`define PFC_POST_MIN    4'h2
`define PFC_POST_MAX    4'h8

// Delay step per code, in picoseconds.
`define PFC_DLY_STEP_PS 12'h096

// Calibration and synchronization busy times in clock cycles.
`define PFC_CAL_CYC     2000
`define PFC_SYNC_CYC    10

`endif

// ### inc/pfc_pkg.sv
// Types and shared functions of the feedback configuration block.
package pfc_pkg;
  `include "pfc_cfg.svh"

  typedef logic [17:0] pfc_ndiv_t;
  typedef logic [3:0]  pfc_code_t;
  typedef logic [21:0] pfc_ratio_t;
  typedef logic [11:0] pfc_ps_t;

  typedef enum logic {PFC_W_IDLE, PFC_W_RESP} pfc_wstate_t;

  // Delay in picoseconds for a 4-bit skew code.
  function automatic pfc_ps_t pfc_delay_ps(input pfc_code_t code);
    pfc_ps_t prod;
    prod = `PFC_DLY_STEP_PS * {8'h00, code};
    return prod;
  endfunction

  // Relative charge-pump gain for a 2-bit code.
  function automatic logic [5:0] pfc_gain_mult(input logic [1:0] code);
    logic [5:0] g;
    case (code)
      2'h0: g = 6'h01;
      2'h1: g = 6'h04;
      2'h2: g = 6'h10;
      default: g = 6'h20;
    endcase
    return g;
  endfunction
endpackage

// ### inc/pfc_fb_if.sv
// Interface between the register file and the feedback sequencer.
`timescale 1ns/10ps
interface pfc_fb_if;
  logic                 wr_pulse;
  logic                 zero_delay;
  pfc_pkg::pfc_ndiv_t   n_div;
  pfc_pkg::pfc_code_t   post_code;
  logic                 cal_start;
  logic                 cal_busy;
  logic                 sync_start;
  logic                 sync_busy;
  pfc_pkg::pfc_ratio_t  total_ratio;

  modport regs (output wr_pulse, zero_delay, n_div, post_code,
                input  cal_start, cal_busy, sync_start, sync_busy, total_ratio);
  modport seq  (input  wr_pulse, zero_delay, n_div, post_code,
                output cal_start, cal_busy, sync_start, sync_busy, total_ratio);
endinterface

// ### rtl/pfc_fb_seq.sv
// Feedback sequencer: calibration and synchronization launch, total ratio.
`timescale 1ns/10ps
`include "pfc_cfg.svh"
module pfc_fb_seq #(
  parameter int CAL_CYC  = `PFC_CAL_CYC,
  parameter int SYNC_CYC = `PFC_SYNC_CYC
) (
  // Clock and reset.
  input  wire logic aclk,
  input  wire logic aresetn,
  // Link to the register file.
  pfc_fb_if.seq     fb
);
  import pfc_pkg::*;

  logic [15:0] cal_cnt;
  logic [15:0] sync_cnt;
  wire         launch_cal = fb.wr_pulse & ~fb.zero_delay;
  wire  [15:0] cal_load   = 16'(CAL_CYC);
  wire  [15:0] sync_load  = 16'(SYNC_CYC);

  // Busy flags follow the counters.
  assign fb.cal_busy  = (cal_cnt != 16'h0000);
  assign fb.sync_busy = (sync_cnt != 16'h0000);

  // R04: calibration launch gated by mode.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_cnt      <= 16'h0000;
      fb.cal_start <= 1'b0;
    end else begin
      fb.cal_start <= launch_cal;
      if (launch_cal) begin
        cal_cnt <= cal_load;
      end else if (cal_cnt != 16'h0000) begin
        cal_cnt <= cal_cnt - 16'h0001;
      end
    end
  end

  // R05: synchronization on every accepted feedback word write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_cnt      <= 16'h0000;
      fb.sync_start <= 1'b0;
    end else begin
      fb.sync_start <= fb.wr_pulse;
      if (fb.wr_pulse) begin
        sync_cnt <= sync_load;
      end else if (sync_cnt != 16'h0000) begin
        sync_cnt <= sync_cnt - 16'h0001;
      end
    end
  end

  // R07: total ratio is divider times post-divider.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fb.total_ratio <= 22'(`PFC_RST_N * `PFC_RST_POST);
    end else begin
      fb.total_ratio <= pfc_ratio_t'(fb.n_div) * pfc_ratio_t'(fb.post_code);
    end
  end
endmodule

// ### bench/pfc_top_chk.sv
// Port assertions of the feedback configuration block.
`timescale 1ns/10ps
module pfc_top_chk #(
  parameter int NUM_OUT  = 8,
  parameter int CAL_CYC  = 8,
  parameter int SYNC_CYC = 2
) (
  // Clock and reset.
  input wire logic                aclk,
  input wire logic                aresetn,
  // Write response.
  input wire logic                s_axi_bvalid,
  input wire logic [1:0]          s_axi_bresp,
  // Pins and loop settings.
  input wire logic                global_output_gate_pin,
  input wire logic [NUM_OUT-1:0]  clk_out_enable,
  input wire pfc_pkg::pfc_code_t  reference_path_delay,
  input wire pfc_pkg::pfc_ps_t    reference_delay_ps,
  input wire pfc_pkg::pfc_ndiv_t  feedback_divider,
  input wire pfc_pkg::pfc_code_t  oscillator_post_divider,
  input wire logic [1:0]          pump_gain_select,
  input wire logic [5:0]          pump_gain_mult,
  input wire pfc_pkg::pfc_ratio_t total_feedback_ratio,
  // Sequence strobes.
  input wire logic                cal_start,
  input wire logic                cal_busy,
  input wire logic                sync_start,
  input wire logic                sync_busy
);
  import pfc_pkg::*;
  // Expected values worked out from the live settings.
  wire pfc_ratio_t ratio_calc = pfc_ratio_t'(feedback_divider) * pfc_ratio_t'(oscillator_post_divider);
  wire pfc_ps_t    ref_ps     = 12'h096 * {8'h00, reference_path_delay};
  wire logic [5:0] gain_exp   = (pump_gain_select == 2'h3) ? 6'h20 : 6'h01 << {pump_gain_select, 1'b0};
  logic [15:0]     cal_len;
  logic [15:0]     sync_len;

  // Busy lengths, counted afresh from each start pulse.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_len  <= 16'h0000;
      sync_len <= 16'h0000;
    end else begin
      cal_len  <= cal_start ? 16'h0001 : (cal_busy ? cal_len + 16'h0001 : cal_len);
      sync_len <= sync_start ? 16'h0001 : (sync_busy ? sync_len + 16'h0001 : sync_len);
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_GATE_OFF: assert property (!global_output_gate_pin |=> clk_out_enable == '0)
    else $error("outputs on with gate low");
  AST_TOTAL: assert property (total_feedback_ratio == ratio_calc)
    else $error("total ratio wrong");
  AST_POST_RANGE: assert property (oscillator_post_divider inside {[4'h2:4'h8]})
    else $error("post divider out of range");
  AST_NDIV_NZ: assert property (feedback_divider != 18'h00000)
    else $error("divider is zero");
  AST_REF_PS: assert property (reference_delay_ps == ref_ps)
    else $error("lag delay wrong");
  AST_GAIN: assert property (pump_gain_mult == gain_exp)
    else $error("pump gain wrong");
  AST_CAL_SYNC: assert property (cal_start |-> sync_start && cal_busy)
    else $error("calibration without sync");
  AST_SYNC_B: assert property (sync_start |-> $rose(s_axi_bvalid) && s_axi_bresp == 2'h0)
    else $error("sync without accepted write");
  AST_CAL_LEN: assert property ($fell(cal_busy) |-> cal_len == CAL_CYC)
    else $error("calibration length wrong");
  AST_SYNC_LEN: assert property ($fell(sync_busy) |-> sync_len == SYNC_CYC)
    else $error("sync length wrong");
endmodule

bind pfc_top pfc_top_chk #(.NUM_OUT(NUM_OUT), .CAL_CYC(CAL_CYC), .SYNC_CYC(SYNC_CYC)) u_chk (.*);

// ### bench/pfc_host.sv
// Register bus host model that writes and reads configuration words.
`timescale 1ns/10ps
module pfc_host (
  // Clock.
  input  wire logic        aclk,
  // Write channels.
  output logic [7:0]       s_axi_awaddr,
  output logic [2:0]       s_axi_awprot,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read channels.
  output logic [7:0]       s_axi_araddr,
  output logic [2:0]       s_axi_arprot,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  localparam int LIMIT = 100;

  // Idle bus at time zero.
  initial begin
    {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
  end

  // One write; released lines show the inverse of the last value.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r, output logic ok);
    ok = 1'b0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int i = 0; i < LIMIT && !ok; i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        ok = 1'b1;
      end
    end
  endtask

  // One read, rready held until the data is sampled.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r, output logic ok);
    ok = 1'b0;
    d = 32'h0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int i = 0; i < LIMIT && !ok; i++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
      end
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        ok = 1'b1;
      end
    end
  endtask
endmodule

// ### bench/pll_feedback_and_output_config_tb.sv
// Self-checking bench for the feedback and output configuration block.
`timescale 1ns/10ps
module pll_feedback_and_output_config_tb;
  import pfc_pkg::*;
  logic        aclk, aresetn, gate, lock;
  logic [7:0]  awaddr, araddr, clk_en;
  logic [2:0]  awprot, arprot;
  logic [31:0] wdata, rdata, last;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, gsel;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic        tap, cal_s, cal_b, syn_s, syn_b;
  logic [5:0]  gmul;
  pfc_code_t   rdly, fdly, post;
  pfc_ps_t     rps, fps;
  pfc_ndiv_t   ndiv, n;
  pfc_ratio_t  ratio;
  int          n_errors, n_compared, n_cal, n_sync, c, s;
  int          gm[4] = '{1, 4, 16, 32};
  int          bad[4] = '{0, 1, 9, 15};

  // Block under test with short busy counts.
  pfc_top #(.NUM_OUT(8), .CAL_CYC(8), .SYNC_CYC(2)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(arprot), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .global_output_gate_pin(gate), .lock_indicator_pin(lock),
    .clk_out_enable(clk_en), .vco_tap_enable(tap), .reference_path_delay(rdly),
    .reference_delay_ps(rps), .feedback_path_delay(fdly), .feedback_delay_ps(fps),
    .feedback_divider(ndiv), .oscillator_post_divider(post), .pump_gain_select(gsel),
    .pump_gain_mult(gmul), .total_feedback_ratio(ratio), .cal_start(cal_s), .cal_busy(cal_b),
    .sync_start(syn_s), .sync_busy(syn_b)
  );

  // Host model on the register bus.
  pfc_host host (
    .aclk(aclk), .s_axi_awaddr(awaddr), .s_axi_awprot(awprot), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(arprot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  // Clock at 100 MHz.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Counts of start pulses seen.
  always @(posedge aclk) begin
    if (cal_s === 1'b1) n_cal <= n_cal + 1;
    if (syn_s === 1'b1) n_sync <= n_sync + 1;
  end

  // Compare one value and count the outcome.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // Print the counts and the verdict, then stop.
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Let two edges land, then sample settled outputs.
  task automatic settle();
    repeat (2) @(posedge aclk);
    #1;
  endtask

  // Write, check the response, let the effects settle.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    logic       ok;
    host.wr(a, d, r, ok);
    if (!ok) begin
      n_errors++;
      print_verdict();
    end else begin
      chk("bresp", r, er);
      settle();
    end
  endtask

  // Read and check data and response.
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    logic        ok;
    host.rd(a, d, r, ok);
    if (!ok) begin
      n_errors++;
      print_verdict();
    end else begin
      chk("rdata", d, ed);
      chk("rresp", r, er);
    end
  endtask

  // Move the gate pin after an edge.
  task automatic set_gate(input logic v);
    @(posedge aclk);
    gate <= v;
    settle();
  endtask

  // Main sequence.
  initial begin
    {gate, lock, aresetn} = 3'b100;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    chk("tap", tap, 32'h0);
    chk("ndiv", ndiv, 32'h2F8);
    chk("post", post, 32'h2);
    chk("gain", gmul, 32'h1);
    chk("rps", rps, 32'h0);
    chk("fps", fps, 32'h0);
    rd(8'h00, 32'h1, 2'h0);
    rd(8'h08, 32'h000802F8, 2'h0);
    rd(8'h10, 32'h5F0, 2'h0);
    rd(8'h0C, 32'h1, 2'h0);
    $display("test reset done");
    wr(8'h04, 32'hA5, 2'h0);
    chk("out", clk_en, 32'hA5);
    set_gate(1'b0);
    chk("out", clk_en, 32'h0);
    set_gate(1'b1);
    wr(8'h00, 32'h0, 2'h0);
    chk("out", clk_en, 32'h0);
    wr(8'h00, 32'h3, 2'h0);
    chk("out", clk_en, 32'hA5);
    chk("tap", tap, 32'h1);
    $display("test outputs done");
    for (int k = 0; k < 16; k++) begin
      wr(8'h00, {24'h0, 4'(k), 4'h1}, 2'h0);
      chk("rdly", rdly, k);
      chk("rps", rps, 32'h96 * k);
    end
    chk("tap", tap, 32'h0);
    $display("test lag done");
    for (int k = 2; k <= 8; k++) begin
      n = (k == 2) ? 18'h1 : (k == 8) ? 18'h3FFFF : 18'(k * 100);
      last = {4'h0, 4'(k + 7), 2'(k), 4'(k), n};
      c = n_cal;
      s = n_sync;
      wr(8'h08, last, 2'h0);
      chk("cal", n_cal, c + 1);
      chk("sync", n_sync, s + 1);
      chk("ndiv", ndiv, n);
      chk("post", post, k);
      chk("gain", gmul, gm[k % 4]);
      chk("gsel", gsel, k % 4);
      chk("fdly", fdly, k + 7);
      chk("fps", fps, 32'h96 * (k + 7));
      chk("ratio", ratio, n * k);
      rd(8'h10, n * k, 2'h0);
    end
    $display("test feedback done");
    s = n_sync;
    wr(8'h08, 32'h000C0000, 2'h2);
    for (int k = 0; k < 4; k++) begin
      wr(8'h08, {10'h0, 4'(bad[k]), 18'h5}, 2'h2);
    end
    chk("sync", n_sync, s);
    rd(8'h08, last, 2'h0);
    wr(8'h14, 32'h1, 2'h2);
    wr(8'h10, 32'h1, 2'h2);
    rd(8'h14, 32'h0, 2'h2);
    $display("test refusals done");
    wr(8'h00, 32'h5, 2'h0);
    c = n_cal;
    s = n_sync;
    wr(8'h08, last, 2'h0);
    chk("cal", n_cal, c);
    chk("sync", n_sync, s + 1);
    wr(8'h00, 32'h1, 2'h0);
    wr(8'h08, last, 2'h0);
    chk("cal", n_cal, c + 1);
    repeat (12) @(posedge aclk);
    $display("test zero delay done");
    print_verdict();
  end
endmodule
